// ---- hw/uhr_defs.vh ----
// Constants for the host register set of the parallel serial-port interface.
// Assumes a single 250 MHz clock and a synchronous active-low reset.
`ifndef UHR_DEFS_VH
`define UHR_DEFS_VH
`define UHR_OFS_DATA 3'h0
`define UHR_OFS_IEN 3'h1
`define UHR_OFS_IID 3'h2
`define UHR_OFS_FMT 3'h3
`define UHR_OFS_HSO 3'h4
`define UHR_OFS_LST 3'h5
`define UHR_OFS_HSI 3'h6
`define UHR_OFS_SCR 3'h7
`define UHR_FMT_DIV_BIT 7
`define UHR_FCR_MODE_BIT 0
`define UHR_FCR_RXCLR_BIT 1
`define UHR_FCR_TXCLR_BIT 2
`define UHR_IID_NONE 4'h1
`define UHR_IID_LINE 4'h6
`define UHR_IID_RXAV 4'h4
`define UHR_IID_TOUT 4'hc
`define UHR_IID_TXE 4'h2
`define UHR_IID_HS 4'h0
`define UHR_TRIG_0 5'h01
`define UHR_TRIG_1 5'h04
`define UHR_TRIG_2 5'h08
`define UHR_TRIG_3 5'h0e
`define UHR_FIFO_DEPTH 16
`define UHR_CHAR_TIMES 4
`define UHR_RESET_BYTE 8'h00
`define UHR_LST_RESET 8'h60
`endif

// ---- hw/uhr_fifo_mem.v ----
// Sixteen-byte storage for the receive FIFO, registered read data.
// Assumes the owner manages pointers and never writes and reads one slot badly.
`timescale 1ns/1ps
module uhr_fifo_mem (
    input wire i_clock,
    input wire i_we,
    input wire [3:0] i_waddr,
    input wire [7:0] i_wdata,
    input wire [3:0] i_raddr,
    output reg [7:0] o_rdata
);
    reg [7:0] mem [0:15];
    always @(posedge i_clock) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule // uhr_fifo_mem

// ---- hw/uhr_regs.v ----
// Host register set with interrupt enables, identification and receive FIFO.
// Assumes host strobes are synchronous one-cycle pulses; serial engine is on the same clock.
`timescale 1ns/1ps
`include "uhr_defs.vh"
module uhr_regs #(
    parameter CHAR_CYCLES = 16'h1000
) (
    input wire i_clock,
    input wire i_rstn,
    input wire [2:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    output reg o_host_irq_out,
    input wire i_rx_valid,
    input wire [7:0] i_rx_byte,
    input wire [3:0] i_rx_errors,
    input wire i_tx_taken,
    input wire i_tx_idle,
    input wire [3:0] i_handshake_lines,
    output reg o_tx_valid,
    output reg [7:0] o_tx_byte,
    output reg [15:0] o_baud_divisor,
    output reg [7:0] o_char_format,
    output reg [7:0] o_handshake_outputs
);
    ////////////////////////////////////////////////////////////////////////
    function [4:0] trig_level;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: trig_level = `UHR_TRIG_0;
                2'h1: trig_level = `UHR_TRIG_1;
                2'h2: trig_level = `UHR_TRIG_2;
                default: trig_level = `UHR_TRIG_3;
            endcase
        end
    endfunction

    reg [3:0] irq_source_enables_reg;
    reg [7:0] fifo_setup_reg;
    reg [7:0] scratch_byte_reg;
    reg [7:0] tx_hold_reg;
    reg tx_full_reg;
    reg [3:0] line_err_reg;
    reg [3:0] line_err_seen_reg;
    reg line_irq_reg;
    reg [3:0] hs_sync1_reg, hs_sync2_reg, hs_prev_reg;
    reg [3:0] hs_delta_reg;
    reg [3:0] rx_wptr_reg, rx_rptr_reg;
    reg [4:0] rx_count_reg;
    reg [7:0] rx_single_reg;
    reg [15:0] idle_cnt_reg;
    reg [2:0] idle_chars_reg;
    reg txe_irq_reg;
    wire [7:0] rx_mem_data;

    wire div_sel = o_char_format[`UHR_FMT_DIV_BIT];
    wire fifo_mode = fifo_setup_reg[`UHR_FCR_MODE_BIT];
    wire wr_data = i_wr && i_addr == `UHR_OFS_DATA && !div_sel;
    wire rd_data = i_rd && i_addr == `UHR_OFS_DATA && !div_sel;
    wire wr_ien = i_wr && i_addr == `UHR_OFS_IEN && !div_sel;
    wire wr_fcr = i_wr && i_addr == `UHR_OFS_IID;
    wire rd_iid = i_rd && i_addr == `UHR_OFS_IID;
    wire rd_lst = i_rd && i_addr == `UHR_OFS_LST;
    wire rd_hsi = i_rd && i_addr == `UHR_OFS_HSI;
    wire rx_ready = fifo_mode ? (rx_count_reg != 5'h00) : (rx_count_reg != 5'h00);
    wire rx_push = i_rx_valid && (!fifo_mode || rx_count_reg != 5'h10);
    wire rx_pop = rd_data && rx_count_reg != 5'h00;
    wire rx_trig = fifo_mode ? (rx_count_reg >= trig_level(fifo_setup_reg[7:6]))
                             : rx_ready;
    wire rx_tout = fifo_mode && rx_count_reg != 5'h00 && idle_chars_reg > 3'h4;
    wire overrun = i_rx_valid && !rx_push ||
                   (!fifo_mode && i_rx_valid && rx_count_reg != 5'h00);
    wire [3:0] err_now = line_err_reg;
    wire [7:0] lst_val = {line_err_seen_reg != 4'h0 && fifo_mode,
                          !tx_full_reg && i_tx_idle, !tx_full_reg,
                          err_now[3:0], rx_ready};
    wire [7:0] hsi_val = {hs_sync2_reg, hs_delta_reg};

    ////////////////////////////////////////////////////////////////////////
    // Interrupt priority: line status, receive, timeout, transmit, handshake.
    reg [3:0] iid_code;
    always @* begin
        if (irq_source_enables_reg[2] && line_irq_reg) begin
            iid_code = `UHR_IID_LINE;
        end else if (irq_source_enables_reg[0] && rx_trig) begin
            iid_code = `UHR_IID_RXAV;
        end else if (irq_source_enables_reg[0] && rx_tout) begin
            iid_code = `UHR_IID_TOUT;
        end else if (irq_source_enables_reg[1] && txe_irq_reg) begin
            iid_code = `UHR_IID_TXE;
        end else if (irq_source_enables_reg[3] && hs_delta_reg != 4'h0) begin
            iid_code = `UHR_IID_HS;
        end else begin
            iid_code = `UHR_IID_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    uhr_fifo_mem u_rx_mem (
        .i_clock(i_clock),
        .i_we(rx_push),
        .i_waddr(rx_wptr_reg),
        .i_wdata(i_rx_byte),
        .i_raddr(rx_pop ? rx_rptr_reg + 4'h1 : rx_rptr_reg),
        .o_rdata(rx_mem_data)
    );

    reg [7:0] rd_mux;
    always @* begin
        case (i_addr)
            `UHR_OFS_DATA: rd_mux = div_sel ? o_baud_divisor[7:0]
                                    : (fifo_mode ? rx_mem_data : rx_single_reg);
            `UHR_OFS_IEN: rd_mux = div_sel ? o_baud_divisor[15:8]
                                   : {4'h0, irq_source_enables_reg};
            `UHR_OFS_IID: rd_mux = {fifo_mode, fifo_mode, 2'h0, iid_code};
            `UHR_OFS_FMT: rd_mux = o_char_format;
            `UHR_OFS_HSO: rd_mux = {4'h0, o_handshake_outputs[3:0]};
            `UHR_OFS_LST: rd_mux = lst_val;
            `UHR_OFS_HSI: rd_mux = hsi_val;
            default: rd_mux = scratch_byte_reg;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge i_clock) begin
        hs_sync1_reg <= i_handshake_lines;
        hs_sync2_reg <= hs_sync1_reg;
        if (!i_rstn) begin
            o_rdata <= `UHR_RESET_BYTE;
            o_host_irq_out <= 1'b0;
            o_tx_valid <= 1'b0;
            o_tx_byte <= `UHR_RESET_BYTE;
            o_baud_divisor <= 16'h0000;
            o_char_format <= `UHR_RESET_BYTE;
            o_handshake_outputs <= `UHR_RESET_BYTE;
            irq_source_enables_reg <= 4'h0;
            fifo_setup_reg <= `UHR_RESET_BYTE;
            scratch_byte_reg <= `UHR_RESET_BYTE;
            tx_hold_reg <= `UHR_RESET_BYTE;
            tx_full_reg <= 1'b0;
            line_err_reg <= 4'h0;
            line_err_seen_reg <= 4'h0;
            line_irq_reg <= 1'b0;
            hs_prev_reg <= 4'h0;
            hs_delta_reg <= 4'h0;
            rx_wptr_reg <= 4'h0;
            rx_rptr_reg <= 4'h0;
            rx_count_reg <= 5'h00;
            rx_single_reg <= `UHR_RESET_BYTE;
            idle_cnt_reg <= 16'h0000;
            idle_chars_reg <= 3'h0;
            txe_irq_reg <= 1'b1;
        end else begin
            o_rdata <= rd_mux;
            o_host_irq_out <= iid_code != `UHR_IID_NONE;
            if (wr_ien) begin
                irq_source_enables_reg <= i_wdata[3:0];
            end
            if (i_wr && div_sel && i_addr == `UHR_OFS_DATA) begin
                o_baud_divisor[7:0] <= i_wdata;
            end
            if (i_wr && div_sel && i_addr == `UHR_OFS_IEN) begin
                o_baud_divisor[15:8] <= i_wdata;
            end
            if (i_wr && i_addr == `UHR_OFS_FMT) begin
                o_char_format <= i_wdata;
            end
            if (i_wr && i_addr == `UHR_OFS_HSO) begin
                o_handshake_outputs <= {4'h0, i_wdata[3:0]};
            end
            if (i_wr && i_addr == `UHR_OFS_SCR) begin
                scratch_byte_reg <= i_wdata;
            end
            if (wr_fcr) begin
                fifo_setup_reg <= {i_wdata[7:6], 5'h00, i_wdata[`UHR_FCR_MODE_BIT]};
            end
            // Transmit holding byte; the serial engine takes it.
            if (wr_data) begin
                tx_hold_reg <= i_wdata;
                tx_full_reg <= 1'b1;
                txe_irq_reg <= 1'b0;
            end else if (i_tx_taken && tx_full_reg) begin
                tx_full_reg <= 1'b0;
                txe_irq_reg <= 1'b1;
            end else if (rd_iid && iid_code == `UHR_IID_TXE) begin
                txe_irq_reg <= 1'b0;
            end
            o_tx_valid <= tx_full_reg && !(i_tx_taken && o_tx_valid);
            o_tx_byte <= tx_hold_reg;
            // Line errors: new error sets over a status read clear.
            line_err_reg <= (rd_lst ? 4'h0 : line_err_reg) |
                            (i_rx_valid ? {i_rx_errors[3:1], overrun} : 4'h0);
            line_err_seen_reg <= (rd_lst ? 4'h0 : line_err_seen_reg) |
                                 (i_rx_valid ? i_rx_errors[3:1] : 4'h0);
            line_irq_reg <= (rd_lst ? 1'b0 : line_irq_reg) |
                            (i_rx_valid && ({i_rx_errors[3:1], overrun} != 4'h0));
            // Handshake deltas: set wins over the read clear.
            hs_prev_reg <= hs_sync2_reg;
            hs_delta_reg <= (rd_hsi ? 4'h0 : hs_delta_reg) |
                            ((hs_sync2_reg ^ hs_prev_reg) & 4'hb) |
                            {1'b0, hs_prev_reg[2] & ~hs_sync2_reg[2], 2'h0};
            // Receive path: FIFO in FIFO mode, one byte otherwise.
            if (wr_fcr && (i_wdata[`UHR_FCR_RXCLR_BIT] ||
                           i_wdata[`UHR_FCR_MODE_BIT] != fifo_mode)) begin
                rx_wptr_reg <= 4'h0;
                rx_rptr_reg <= 4'h0;
                rx_count_reg <= 5'h00;
            end else if (fifo_mode) begin
                if (rx_push) begin
                    rx_wptr_reg <= rx_wptr_reg + 4'h1;
                end
                if (rx_pop) begin
                    rx_rptr_reg <= rx_rptr_reg + 4'h1;
                end
                rx_count_reg <= rx_count_reg + {4'h0, rx_push} - {4'h0, rx_pop};
            end else begin
                if (i_rx_valid) begin
                    rx_single_reg <= i_rx_byte;
                    rx_count_reg <= 5'h01;
                end else if (rx_pop) begin
                    rx_count_reg <= 5'h00;
                end
            end
            // Idle character-time counter for the timeout.
            if (i_rx_valid || rx_pop || rx_count_reg == 5'h00) begin
                idle_cnt_reg <= 16'h0000;
                idle_chars_reg <= 3'h0;
            end else if (idle_cnt_reg == CHAR_CYCLES - 16'h0001) begin
                idle_cnt_reg <= 16'h0000;
                if (idle_chars_reg != 3'h7) begin
                    idle_chars_reg <= idle_chars_reg + 3'h1;
                end
            end else begin
                idle_cnt_reg <= idle_cnt_reg + 16'h0001;
            end
        end
    end
endmodule // uhr_regs

// ---- testbench/tb.sv ----
// Self-checking bench for the host register set.
// Assumes the host model owns the register bus; the bench drives the serial side.
`timescale 1ns/1ps
module tb;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic i_rx_valid = 1'b0;
    logic i_tx_taken = 1'b0;
    logic [7:0] i_rx_byte = 8'h00;
    logic [3:0] i_rx_errors = 4'h0;
    logic [3:0] i_handshake_lines = 4'h0;
    wire [2:0] i_addr;
    wire i_wr, i_rd, o_host_irq_out, o_tx_valid;
    wire [7:0] i_wdata, o_rdata, o_tx_byte, o_char_format, o_handshake_outputs;
    wire [15:0] o_baud_divisor;
    integer n_fail = 0;
    integer total_checks = 0;
    integer cyc = 0;
    integer k;
    logic [7:0] r;
    always #2 i_clock = ~i_clock;
    uhr_host_model u_uhr_host_model (.i_clock, .i_rdata(o_rdata), .o_addr(i_addr),
        .o_wr(i_wr), .o_rd(i_rd), .o_wdata(i_wdata));
    uhr_regs #(.CHAR_CYCLES(16'h0008)) u_uhr_regs (.i_clock, .i_rstn, .i_addr, .i_wr, .i_rd,
        .i_wdata, .o_rdata, .o_host_irq_out, .i_rx_valid, .i_rx_byte, .i_rx_errors, .i_tx_taken,
        .i_tx_idle(1'b1), .i_handshake_lines, .o_tx_valid, .o_tx_byte, .o_baud_divisor,
        .o_char_format, .o_handshake_outputs);
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        begin
            total_checks = total_checks + 1;
            if (s !== e) begin
                n_fail = n_fail + 1;
                $display("unexpected %s expected %h seen %h", n, e, s);
            end
        end
    endtask
    task wirq(input logic e, input integer n);
        begin
            for (k = 0; k < n && o_host_irq_out !== e; k = k + 1) @(negedge i_clock);
            chk("irq", o_host_irq_out, e);
        end
    endtask
    task rdc(input logic [2:0] a, input logic [7:0] e);
        begin
            u_uhr_host_model.rd(a, r);
            chk("rdata", r, e);
        end
    endtask
    task rxb(input logic [7:0] b, input logic [3:0] e);
        begin
            @(negedge i_clock);
            i_rx_byte = b;
            i_rx_errors = e;
            i_rx_valid = 1'b1;
            @(negedge i_clock);
            i_rx_valid = 1'b0;
        end
    endtask
    task results;
        begin
            if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task s_ien;
        begin
            rdc(3'h1, 8'h00);
            chk("irq", o_host_irq_out, 1'b0);
            u_uhr_host_model.wr(3'h1, 8'hff);
            rdc(3'h1, 8'h0f);
            wirq(1'b1, 4);
            u_uhr_host_model.wr(3'h1, 8'h00);
            wirq(1'b0, 4);
            rdc(3'h2, 8'h01);
            u_uhr_host_model.wr(3'h1, 8'h02);
            u_uhr_host_model.wr(3'h0, 8'ha5);
            // The transmit byte shows one cycle after the holding register takes it.
            @(negedge i_clock);
            chk("tx", {o_tx_valid, o_tx_byte}, 16'h01a5);
            wirq(1'b0, 4);
            i_tx_taken = 1'b1;
            @(negedge i_clock);
            i_tx_taken = 1'b0;
            wirq(1'b1, 4);
            rdc(3'h2, 8'h02);
            wirq(1'b0, 4);
        end
    endtask
    task s_div;
        begin
            u_uhr_host_model.wr(3'h3, 8'h80);
            u_uhr_host_model.wr(3'h0, 8'h34);
            u_uhr_host_model.wr(3'h1, 8'h12);
            chk("divisor", o_baud_divisor, 16'h1234);
            rdc(3'h0, 8'h34);
            rdc(3'h1, 8'h12);
            u_uhr_host_model.wr(3'h3, 8'h03);
            chk("format", o_char_format, 16'h0003);
            rdc(3'h3, 8'h03);
            rdc(3'h1, 8'h02);
            u_uhr_host_model.wr(3'h4, 8'hff);
            chk("hs_out", o_handshake_outputs, 16'h000f);
            rdc(3'h4, 8'h0f);
            u_uhr_host_model.wr(3'h7, 8'hc3);
            rdc(3'h7, 8'hc3);
            u_uhr_host_model.wr(3'h5, 8'hff);
            rdc(3'h5, 8'h60);
        end
    endtask
    task s_rx;
        begin
            u_uhr_host_model.wr(3'h1, 8'h01);
            rxb(8'h5a, 4'h0);
            wirq(1'b1, 4);
            rdc(3'h2, 8'h04);
            rdc(3'h0, 8'h5a);
            wirq(1'b0, 4);
        end
    endtask
    task s_fifo;
        begin
            u_uhr_host_model.wr(3'h2, 8'h41);
            rxb(8'h10, 4'h0);
            rxb(8'h11, 4'h0);
            rxb(8'h12, 4'h0);
            chk("irq", o_host_irq_out, 1'b0);
            rxb(8'h13, 4'h0);
            wirq(1'b1, 4);
            rdc(3'h2, 8'hc4);
            rdc(3'h0, 8'h10);
            wirq(1'b0, 4);
            repeat (20) @(negedge i_clock);
            chk("irq", o_host_irq_out, 1'b0);
            wirq(1'b1, 80);
            rdc(3'h2, 8'hcc);
        end
    endtask
    task s_line_hs;
        begin
            u_uhr_host_model.wr(3'h1, 8'h04);
            wirq(1'b0, 4);
            rxb(8'h20, 4'h4);
            wirq(1'b1, 4);
            u_uhr_host_model.rd(3'h5, r);
            chk("framing", r[3], 1'b1);
            wirq(1'b0, 4);
            u_uhr_host_model.wr(3'h1, 8'h08);
            i_handshake_lines = 4'h1;
            wirq(1'b1, 12);
            u_uhr_host_model.rd(3'h6, r);
            chk("handshake", r[4:0], 5'h11);
            wirq(1'b0, 4);
        end
    endtask
    initial begin
        repeat (4) @(negedge i_clock);
        i_rstn = 1'b1;
        s_ien;
        s_div;
        s_rx;
        s_fifo;
        s_line_hs;
        results;
    end
    always @(posedge i_clock) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_fail = n_fail + 1;
            results;
        end
    end
endmodule // tb

// ---- testbench/uhr_host_model.sv ----
// Host processor model: one register access per task call.
// Assumes the block samples strobes on the rising edge.
`timescale 1ns/1ps
module uhr_host_model (
    input wire i_clock,
    input wire [7:0] i_rdata,
    output logic [2:0] o_addr = 3'h0,
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0,
    output logic [7:0] o_wdata = 8'h00
);
    task wr(input logic [2:0] a, input logic [7:0] d);
        begin
            @(negedge i_clock);
            o_addr = a;
            o_wdata = d;
            o_wr = 1'b1;
            @(negedge i_clock);
            o_wr = 1'b0;
            o_wdata = ~d;
        end
    endtask
    task rd(input logic [2:0] a, output logic [7:0] d);
        begin
            @(negedge i_clock);
            o_addr = a;
            o_rd = 1'b1;
            @(negedge i_clock);
            o_rd = 1'b0;
            d = i_rdata;
        end
    endtask
endmodule // uhr_host_model

// ---- testbench/uhr_regs_assertions.sv ----
// Checker for the host register set, bound to uhr_regs.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
module uhr_regs_assertions #(
    parameter CHAR_CYCLES = 16'h1000
) (
    input wire i_clock, i_rstn, i_wr, i_rd, i_rx_valid, i_tx_taken, i_tx_idle,
    input wire [2:0] i_addr,
    input wire [7:0] i_wdata, i_rx_byte,
    input wire [3:0] i_rx_errors, i_handshake_lines,
    input wire [7:0] o_rdata, o_tx_byte, o_char_format, o_handshake_outputs,
    input wire o_host_irq_out, o_tx_valid,
    input wire [15:0] o_baud_divisor
);
    reg [3:0] ien_reg;
    reg [1:0] trig_reg;
    always @(posedge i_clock) begin
        if (!i_rstn) begin
            ien_reg <= 4'h0;
            trig_reg <= 2'h0;
        end else if (i_wr && i_addr == 3'h1 && !o_char_format[7]) begin
            ien_reg <= i_wdata[3:0];
        end else if (i_wr && i_addr == 3'h2) begin
            trig_reg <= i_wdata[7:6];
        end
    end
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    a_ien_readback: assert property (i_addr == 3'h1 && !i_wr && !o_char_format[7] |=>
        o_rdata == {4'h0, $past(ien_reg)}) else $error("enable readback wrong");
    a_irq_all_off: assert property ((ien_reg == 4'h0) [*2] |-> !o_host_irq_out)
        else $error("irq with enables clear");
    a_hs_irq: assert property (ien_reg[3]
        && $changed({i_handshake_lines[3], i_handshake_lines[1:0]}) |-> ##[1:8]
        (o_host_irq_out || !ien_reg[3] || (i_rd && i_addr == 3'h6))) else $error("no hs irq");
    a_line_irq: assert property (ien_reg[2] && i_rx_valid && i_rx_errors[3:1] != 3'h0
        |-> ##[1:3] (o_host_irq_out || (i_rd && i_addr == 3'h5))) else $error("no line irq");
    a_rx_irq: assert property (ien_reg[0] && trig_reg == 2'h0 && i_rx_valid
        |-> ##[1:3] (o_host_irq_out || (i_rd && i_addr == 3'h0))) else $error("no rx irq");
    a_div_low: assert property (i_wr && i_addr == 3'h0 && o_char_format[7] |=>
        o_baud_divisor[7:0] == $past(i_wdata)) else $error("divisor low lost");
    a_div_high: assert property (i_wr && i_addr == 3'h1 && o_char_format[7] |=>
        o_baud_divisor[15:8] == $past(i_wdata)) else $error("divisor high lost");
    // The byte reaches the serial side two edges after the write: holding register first.
    a_tx_load: assert property ((i_wr && i_addr == 3'h0 && !o_char_format[7] && !i_tx_taken)
        ##1 !i_tx_taken |=> o_tx_valid && o_tx_byte == $past(i_wdata, 2))
        else $error("tx byte lost");
    c_hs: cover property (ien_reg[3] && o_host_irq_out);
    c_div: cover property (i_wr && i_addr == 3'h1 && o_char_format[7]);
    c_rx: cover property (ien_reg[0] && i_rx_valid);
endmodule // uhr_regs_assertions

bind uhr_regs uhr_regs_assertions #(.CHAR_CYCLES(CHAR_CYCLES)) u_uhr_regs_assertions (
    .i_clock, .i_rstn, .i_wr, .i_rd, .i_rx_valid, .i_tx_taken, .i_tx_idle, .i_addr, .i_wdata,
    .i_rx_byte, .i_rx_errors, .i_handshake_lines, .o_rdata, .o_tx_byte, .o_char_format,
    .o_handshake_outputs, .o_host_irq_out, .o_tx_valid, .o_baud_divisor);
